// file: core/tmeh_defs.svh
`ifndef TMEH_DEFS_SVH
`define TMEH_DEFS_SVH

// ==========================================================
// Register offsets, as seen on the register access port
`define TMEH_ADDR_WAFER_POSITION_INFO 16'h1004
`define TMEH_ADDR_NVM_ECC_HEALTH_STATUS 16'h1005

// ==========================================================
// Health register field positions
`define TMEH_BIT_RED_ZONE_SINGLE_BIT_FLAG 15
`define TMEH_BIT_RED_ZONE_DOUBLE_BIT_FLAG 14
`define TMEH_BIT_YELLOW_ZONE_SINGLE_BIT_FLAG 13
`define TMEH_BIT_YELLOW_ZONE_DOUBLE_BIT_FLAG 12
`define TMEH_BIT_GREEN_ZONE_SINGLE_BIT_FLAG 11
`define TMEH_BIT_GREEN_ZONE_DOUBLE_BIT_FLAG 10
`define TMEH_HEALTH_RSVD_MSB 9
`define TMEH_HEALTH_RSVD_LSB 0

// ==========================================================
// Wafer position register field positions
`define TMEH_WAFER_Y_MSB 14
`define TMEH_WAFER_Y_LSB 8
`define TMEH_WAFER_X_MSB 6
`define TMEH_WAFER_X_LSB 0

// ==========================================================
// Reset values
`define TMEH_HEALTH_RESET 16'h0000
`define TMEH_WAFER_RESET 16'h0000
`define TMEH_RSVD_VALUE 10'h000

`endif

// file: core/tmeh_pkg.sv
package tmeh_pkg;

	// ==========================================================
	// Load sequencer states
	typedef enum logic [1:0] {
		TMEH_ST_START,
		TMEH_ST_LOAD,
		TMEH_ST_DRAIN,
		TMEH_ST_DONE
	} tmeh_state_t;

	// ==========================================================
	// Memory zones
	typedef enum logic [1:0] {
		TMEH_ZONE_GREEN,
		TMEH_ZONE_YELLOW,
		TMEH_ZONE_RED
	} tmeh_zone_t;

endpackage

// file: core/tmeh_secded.sv
`timescale 1ns/1ps

// ==========================================================
// Extended Hamming decoder: bit 0 is overall parity, bits 1..N sit at
// Hamming positions, check bits at the powers of two.
module tmeh_secded
	import tmeh_pkg::*;
#(
	parameter int DATA_W = 16,
	parameter int CHK_W = 5
) (
	input wire logic [DATA_W+CHK_W:0] i_code,
	output logic [DATA_W-1:0] o_data,
	output logic o_single,
	output logic o_double
);

	localparam int N = DATA_W + CHK_W;

	// Check bits must reach every position, and a spare one would push data past the output
	if ((1 << CHK_W) < N + 1) begin
		$error("tmeh_secded: too few check bits for the data width");
	end
	if ((1 << (CHK_W - 1)) > N) begin
		$error("tmeh_secded: more check bits than the data width needs");
	end

	// Returns one when a position is a power of two (a check bit)
	function automatic logic is_chk(input int pos);
		return (pos & (pos - 1)) == 0;
	endfunction

	// Syndrome, overall parity, repair and data extraction
	always_comb begin
		logic [CHK_W-1:0] syn;
		logic par;
		logic [N:0] fixed;
		int k;
		syn = '0;
		par = ^i_code;
		fixed = i_code;
		k = 0;
		o_data = '0;
		for (int i = 1; i <= N; i++) begin
			if (i_code[i]) begin
				syn = syn ^ CHK_W'(i);
			end
		end
		o_single = par; // Odd weight: one flipped bit, repairable
		o_double = !par && (syn != '0); // Even weight with syndrome: detect only
		if (par && (syn != '0) && (int'(syn) <= N)) begin
			fixed[syn] = ~i_code[syn];
		end
		for (int i = 1; i <= N; i++) begin
			if (!is_chk(i)) begin
				o_data[k] = fixed[i];
				k++;
			end
		end
	end

endmodule

// file: core/tmeh_top.sv
`timescale 1ns/1ps
`include "tmeh_defs.svh"

// Summary of operation
// - ECC repairs single errors, detects double errors
// - Three zones: green, yellow, red, reported apart
// - No user write path into stored memory
// - Red single error sets bit 15
// - Red double error sets bit 14
// - Yellow single error sets bit 13
// - Yellow double error sets bit 12
// - Green single error sets bit 11
// - Green double error sets bit 10
// - Health bits 9:0 reserved, read-only
// - Wafer Y at 14:8, X at 6:0
module tmeh_top
	import tmeh_pkg::*;
#(
	parameter int DATA_W = 16,
	parameter int CHK_W = 5,
	parameter int ADDR_W = 6,
	parameter int WORDS = 48,
	parameter int YELLOW_BASE = 16,
	parameter int RED_BASE = 32,
	parameter int WAFER_WORD = 0
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	// Trim memory read port, one cycle read latency
	output logic o_nvm_rd_en,
	output logic [ADDR_W-1:0] o_nvm_addr,
	input wire logic [DATA_W+CHK_W:0] i_nvm_code,
	// Corrected words delivered to the trim shadow
	output logic o_trim_valid,
	output logic [ADDR_W-1:0] o_trim_addr,
	output logic [DATA_W-1:0] o_trim_data,
	output logic o_load_done,
	// Register access from the serial command engine
	input wire logic i_reg_rd,
	input wire logic i_reg_wr,
	input wire logic [15:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	output logic o_reg_ack,
	output logic [15:0] o_reg_rdata
);

	// ==========================================================
	// Elaboration checks
	if (DATA_W < 16) begin
		$error("tmeh_top: data width must hold a 16-bit wafer word");
	end
	if (WORDS < 1 || WORDS > (1 << ADDR_W)) begin
		$error("tmeh_top: word count does not fit the address width");
	end
	if (!(YELLOW_BASE <= RED_BASE && RED_BASE <= WORDS)) begin
		$error("tmeh_top: zone bounds out of order");
	end
	if (WAFER_WORD >= WORDS) begin
		$error("tmeh_top: wafer word outside memory");
	end

	// Zone of a word address
	function automatic tmeh_zone_t zone_of(input logic [ADDR_W-1:0] a);
		if (int'(a) >= RED_BASE) begin
			return TMEH_ZONE_RED;
		end else if (int'(a) >= YELLOW_BASE) begin
			return TMEH_ZONE_YELLOW;
		end
		return TMEH_ZONE_GREEN;
	endfunction

	// ==========================================================
	// ECC decoder
	logic [DATA_W-1:0] dec_data;
	logic dec_single;
	logic dec_double;

	tmeh_secded #(
		.DATA_W(DATA_W),
		.CHK_W(CHK_W)
	) u_secded (
		.i_code(i_nvm_code),
		.o_data(dec_data),
		.o_single(dec_single),
		.o_double(dec_double)
	);

	// ==========================================================
	// Load sequencer state
	tmeh_state_t state_q, state_d;
	logic [ADDR_W-1:0] rd_addr_q, rd_addr_d;
	logic [ADDR_W-1:0] chk_addr_q, chk_addr_d;
	logic chk_vld_q, chk_vld_d;
	logic trim_vld_q, trim_vld_d;
	logic [ADDR_W-1:0] trim_addr_q, trim_addr_d;
	logic [DATA_W-1:0] trim_data_q, trim_data_d;
	logic [5:0] flags_q, flags_d;
	logic [15:0] wafer_q, wafer_d;
	logic rd_en;

	// Next-state logic for the one-pass read and check after reset
	always_comb begin
		tmeh_zone_t z;
		z = zone_of(chk_addr_q);
		state_d = state_q;
		rd_addr_d = rd_addr_q;
		chk_addr_d = rd_addr_q;
		chk_vld_d = 1'b0;
		trim_vld_d = 1'b0;
		trim_addr_d = trim_addr_q;
		trim_data_d = trim_data_q;
		flags_d = flags_q;
		wafer_d = wafer_q;
		rd_en = 1'b0;
		case (state_q)
			TMEH_ST_START: begin
				rd_addr_d = '0;
				state_d = TMEH_ST_LOAD;
			end
			TMEH_ST_LOAD: begin
				rd_en = 1'b1; // Reads only during load; the last word is checked in drain
				chk_vld_d = 1'b1;
				if (int'(rd_addr_q) == WORDS - 1) begin
					state_d = TMEH_ST_DRAIN;
				end else begin
					rd_addr_d = rd_addr_q + ADDR_W'(1);
				end
			end
			TMEH_ST_DRAIN: begin
				state_d = TMEH_ST_DONE;
			end
			TMEH_ST_DONE: begin
				state_d = TMEH_ST_DONE; // Flags frozen until reset
			end
			default: begin
				state_d = TMEH_ST_START;
			end
		endcase
		if (chk_vld_q) begin
			trim_vld_d = 1'b1;
			trim_addr_d = chk_addr_q;
			trim_data_d = dec_data; // Repaired word goes out
			if (int'(chk_addr_q) == WAFER_WORD) begin
				wafer_d = 16'h0000;
				wafer_d[`TMEH_WAFER_Y_MSB:`TMEH_WAFER_Y_LSB] =
					dec_data[`TMEH_WAFER_Y_MSB:`TMEH_WAFER_Y_LSB];
				wafer_d[`TMEH_WAFER_X_MSB:`TMEH_WAFER_X_LSB] =
					dec_data[`TMEH_WAFER_X_MSB:`TMEH_WAFER_X_LSB];
			end
			// Per-zone sticky flags, set only
			case (z)
				TMEH_ZONE_RED: begin
					flags_d[5] = flags_q[5] | dec_single;
					flags_d[4] = flags_q[4] | dec_double;
				end
				TMEH_ZONE_YELLOW: begin
					flags_d[3] = flags_q[3] | dec_single;
					flags_d[2] = flags_q[2] | dec_double;
				end
				TMEH_ZONE_GREEN: begin
					flags_d[1] = flags_q[1] | dec_single;
					flags_d[0] = flags_q[0] | dec_double;
				end
				default: begin
					flags_d = flags_q;
				end
			endcase
		end
	end

	// Sequencer registers
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state_q <= TMEH_ST_START;
			rd_addr_q <= '0;
			chk_addr_q <= '0;
			chk_vld_q <= 1'b0;
			trim_vld_q <= 1'b0;
			trim_addr_q <= '0;
			trim_data_q <= '0;
			flags_q <= 6'h0;
			wafer_q <= `TMEH_WAFER_RESET;
		end else begin
			state_q <= state_d;
			rd_addr_q <= rd_addr_d;
			chk_addr_q <= chk_addr_d;
			chk_vld_q <= chk_vld_d;
			trim_vld_q <= trim_vld_d;
			trim_addr_q <= trim_addr_d;
			trim_data_q <= trim_data_d;
			flags_q <= flags_d;
			wafer_q <= wafer_d;
		end
	end

	// Memory port and shadow outputs; the memory port is read-only
	assign o_nvm_rd_en = rd_en;
	assign o_nvm_addr = rd_addr_q;
	assign o_trim_valid = trim_vld_q;
	assign o_trim_addr = trim_addr_q;
	assign o_trim_data = trim_data_q;
	assign o_load_done = (state_q == TMEH_ST_DONE);

	// ==========================================================
	// Register access
	logic [15:0] health;
	logic ack_q, ack_d;
	logic [15:0] rdata_q, rdata_d;
	logic wr_unused;

	// Health word image; reserved bits fixed
	always_comb begin
		health = `TMEH_HEALTH_RESET;
		health[`TMEH_BIT_RED_ZONE_SINGLE_BIT_FLAG] = flags_q[5];
		health[`TMEH_BIT_RED_ZONE_DOUBLE_BIT_FLAG] = flags_q[4];
		health[`TMEH_BIT_YELLOW_ZONE_SINGLE_BIT_FLAG] = flags_q[3];
		health[`TMEH_BIT_YELLOW_ZONE_DOUBLE_BIT_FLAG] = flags_q[2];
		health[`TMEH_BIT_GREEN_ZONE_SINGLE_BIT_FLAG] = flags_q[1];
		health[`TMEH_BIT_GREEN_ZONE_DOUBLE_BIT_FLAG] = flags_q[0];
		health[`TMEH_HEALTH_RSVD_MSB:`TMEH_HEALTH_RSVD_LSB] = `TMEH_RSVD_VALUE;
	end

	// Read decode; writes are acknowledged and dropped
	always_comb begin
		ack_d = i_reg_rd | i_reg_wr; // Commands arrive from the serial engine
		rdata_d = rdata_q;
		if (i_reg_rd) begin
			case (i_reg_addr)
				`TMEH_ADDR_WAFER_POSITION_INFO: rdata_d = wafer_q;
				`TMEH_ADDR_NVM_ECC_HEALTH_STATUS: rdata_d = health;
				default: rdata_d = 16'h0000;
			endcase
		end
	end

	// Write data has no destination in this block
	assign wr_unused = ^i_reg_wdata;

	// Register access response registers
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			ack_q <= 1'b0;
			rdata_q <= 16'h0000;
		end else begin
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	assign o_reg_ack = ack_q;
	assign o_reg_rdata = rdata_q;

endmodule

// file: verification/tmeh_asserts.sv
`timescale 1ns/1ps

// ==========================================================
// Port checks of the trim health block
module tmeh_asserts #(
	parameter int ADDR_W = 6
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_reg_rd,
	input wire logic i_reg_wr,
	input wire logic [15:0] i_reg_addr,
	input wire logic o_reg_ack,
	input wire logic [15:0] o_reg_rdata,
	input wire logic o_nvm_rd_en,
	input wire logic [ADDR_W-1:0] o_nvm_addr,
	input wire logic o_trim_valid,
	input wire logic [ADDR_W-1:0] o_trim_addr,
	input wire logic o_load_done
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	// Register answers
	chk_ack_follows: assert property ((i_reg_rd || i_reg_wr) |=> o_reg_ack) else $error("ack late");
	chk_ack_cause: assert property (o_reg_ack |-> $past(i_reg_rd || i_reg_wr)) else $error("stray ack");
	chk_rsvd_zero: assert property (i_reg_rd && i_reg_addr == 16'h1005 |=> o_reg_rdata[9:0] == 10'h000)
		else $error("reserved bits set");
	chk_wafer_pad: assert property (i_reg_rd && i_reg_addr == 16'h1004 |=> !o_reg_rdata[15] && !o_reg_rdata[7])
		else $error("wafer pad bits set");
	chk_unmapped_zero: assert property (i_reg_rd && i_reg_addr[15:1] != 15'h0802 |=> o_reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	chk_rdata_hold: assert property (!$past(i_reg_rd) && !$past(i_rst) |-> $stable(o_reg_rdata))
		else $error("read data moved");
	// Load sequence
	chk_done_holds: assert property (o_load_done |=> o_load_done) else $error("done dropped");
	chk_idle_done: assert property (o_load_done |-> !o_nvm_rd_en) else $error("load restarted");
	chk_trim_delay: assert property (o_nvm_rd_en |-> ##2 o_trim_valid && o_trim_addr == $past(o_nvm_addr, 2))
		else $error("trim word late");
	chk_addr_step: assert property (o_nvm_rd_en && $past(o_nvm_rd_en) |-> o_nvm_addr == ADDR_W'($past(o_nvm_addr) + 1))
		else $error("address skipped");
	cover property (o_trim_valid);
	cover property (i_reg_wr);
	cover property (o_load_done && i_reg_rd);
endmodule

bind tmeh_top tmeh_asserts #(.ADDR_W(ADDR_W)) u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_rd(i_reg_rd),
	.i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .o_reg_ack(o_reg_ack), .o_reg_rdata(o_reg_rdata),
	.o_nvm_rd_en(o_nvm_rd_en), .o_nvm_addr(o_nvm_addr), .o_trim_valid(o_trim_valid),
	.o_trim_addr(o_trim_addr), .o_load_done(o_load_done));

// file: verification/tmeh_mem_model.sv
`timescale 1ns/1ps

// ==========================================================
// Trim memory: one-cycle read, faults planted at word 5 of a zone
module tmeh_mem_model (
	input wire logic i_core_clk,
	input wire logic i_rd_en,
	input wire logic [5:0] i_addr,
	input wire logic [5:0] i_err,
	output logic [21:0] o_code
);
	// Extended Hamming encoder
	function automatic logic [21:0] enc(input logic [15:0] d);
		logic [21:0] c;
		int j;
		c = '0;
		j = 0;
		for (int p = 1; p < 22; p++) begin
			if ((p & (p - 1)) != 0) begin
				c[p] = d[j];
				j++;
			end
		end
		for (int k = 0; k < 5; k++) begin
			for (int p = 1; p < 22; p++) begin
				if (p[k] && p != (1 << k)) c[1 << k] ^= c[p];
			end
		end
		c[0] = ^c;
		return c;
	endfunction
	initial o_code = '0;
	// Idle cycles toggle the output, alternating the inverted and the true last word
	always @(posedge i_core_clk) begin
		logic [21:0] c;
		logic [1:0] m;
		c = enc(16'hDA80 ^ (16'(i_addr) * 16'h0123));
		m = i_err[2 * i_addr[5:4] +: 2];
		if (i_addr[3:0] == 4'h5 && m != 2'h0) c[7] = ~c[7];
		if (i_addr[3:0] == 4'h5 && m == 2'h2) c[12] = ~c[12];
		o_code <= i_rd_en ? c : ~o_code;
	end
endmodule

// file: verification/tmeh_top_tb.sv
`timescale 1ns/1ps

// ==========================================================
// Bench: load with planted faults, then read the flags
module tmeh_top_tb;
	import tmeh_pkg::*;
	logic i_core_clk = 0, i_rst = 1, i_reg_rd = 0, i_reg_wr = 0;
	logic [15:0] i_reg_addr = 0, i_reg_wdata = 0, o_reg_rdata, o_trim_data, rd_v;
	logic [5:0] err = 0, o_nvm_addr, o_trim_addr, exp_a;
	logic [21:0] i_nvm_code;
	logic o_nvm_rd_en, o_trim_valid, o_load_done, o_reg_ack;
	int failures = 0, checks = 0;
	// Fault modes {red, yellow, green}: 1 single, 2 double
	localparam logic [5:0] ERR [8] = '{6'h00, 6'h10, 6'h20, 6'h04, 6'h08, 6'h01, 6'h02, 6'h19};
	localparam logic [15:0] HLT [8] = '{16'h0000, 16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0400, 16'h9800};
	always #2 i_core_clk = ~i_core_clk;
	tmeh_top uut (.i_core_clk(i_core_clk), .i_rst(i_rst), .o_nvm_rd_en(o_nvm_rd_en), .o_nvm_addr(o_nvm_addr),
		.i_nvm_code(i_nvm_code), .o_trim_valid(o_trim_valid), .o_trim_addr(o_trim_addr), .o_trim_data(o_trim_data),
		.o_load_done(o_load_done), .i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
		.i_reg_wdata(i_reg_wdata), .o_reg_ack(o_reg_ack), .o_reg_rdata(o_reg_rdata));
	tmeh_mem_model u_mem (.i_core_clk(i_core_clk), .i_rd_en(o_nvm_rd_en), .i_addr(o_nvm_addr), .i_err(err),
		.o_code(i_nvm_code));
	function automatic logic [15:0] dat(input logic [5:0] a);
		return 16'hDA80 ^ (16'(a) * 16'h0123);
	endfunction
	task cmp(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One register access, write when wr is set
	task acc(input logic wr, input logic [15:0] a, output logic [15:0] d);
		@(posedge i_core_clk);
		i_reg_rd <= !wr;
		i_reg_wr <= wr;
		i_reg_addr <= a;
		i_reg_wdata <= 16'hFFFF;
		@(posedge i_core_clk);
		i_reg_rd <= 0;
		i_reg_wr <= 0;
		#1;
		cmp({15'h0, o_reg_ack}, 16'h0001);
		d = o_reg_rdata;
	endtask
	task reboot(input logic [5:0] e);
		@(posedge i_core_clk);
		i_rst <= 1;
		err <= e;
		repeat (2) @(posedge i_core_clk);
		i_rst <= 0;
		for (int i = 0; i < 80 && o_load_done !== 1'b1; i++) begin
			@(posedge i_core_clk);
			#1;
		end
		cmp({15'h0, o_load_done}, 16'h0001);
		cmp({10'h0, exp_a}, 16'h002F);
	endtask
	task wrap_up();
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Corrected word stream, in address order
	always @(posedge i_core_clk) begin
		if (i_rst) exp_a <= 0;
		else if (o_trim_valid === 1'b1) begin
			cmp({10'h0, o_trim_addr}, {10'h0, exp_a});
			if (!(err[2 * exp_a[5:4] +: 2] == 2'h2 && exp_a[3:0] == 4'h5)) cmp(o_trim_data, dat(exp_a));
			exp_a <= exp_a + 1;
		end
	end
	initial begin
		for (int r = 0; r < 8; r++) begin
			reboot(ERR[r]);
			acc(0, 16'h1005, rd_v);
			cmp(rd_v, HLT[r]);
			acc(0, 16'h1004, rd_v);
			cmp(rd_v, 16'h5A00);
			$display("row %0d done", r);
		end
		// Writes leave the flags, an unmapped read gives zero
		acc(1, 16'h1005, rd_v);
		acc(0, 16'h1005, rd_v);
		cmp(rd_v, 16'h9800);
		acc(0, 16'h1006, rd_v);
		cmp(rd_v, 16'h0000);
		$display("write and unmapped test done");
		// A further reset with no faults clears the latched flags
		reboot(6'h00);
		acc(0, 16'h1005, rd_v);
		cmp(rd_v, 16'h0000);
		$display("reset test done");
		wrap_up();
	end
	initial begin
		#40000;
		failures++;
		wrap_up();
	end
endmodule
